// ---- shared/cab_pkg.sv ----
package cab_pkg;

   // ----------------------------------------------------------------------
   // Widths, bit positions and reset values
   // ----------------------------------------------------------------------
   localparam int REG_COUNT = 32;
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;
   localparam logic [4:0] PAIR_PRODUCT_LO = 5'h00;
   localparam logic [4:0] PAIR_PRODUCT_HI = 5'h01;
   localparam logic [4:0] PAIR_POINTER_LO = 5'h1e;
   localparam logic [4:0] PAIR_POINTER_HI = 5'h1f;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ----------------------------------------------------------------------
   // Register port map
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_GPR_LAST = 8'h1f;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_PC_LO = 8'h21;
   localparam logic [7:0] ADDR_PC_HI = 8'h22;

   // ----------------------------------------------------------------------
   // Extra cycles an instruction holds the unit after it is taken
   // ----------------------------------------------------------------------
   localparam logic [1:0] WAIT_1 = 2'h0;
   localparam logic [1:0] WAIT_2 = 2'h1;
   localparam logic [1:0] WAIT_3 = 2'h2;
   localparam logic [1:0] WAIT_4 = 2'h3;

   typedef enum logic [5:0] {
      OP_IDLE = 6'b000000, OP_SUM = 6'b000001, OP_SUM_CARRY = 6'b000010,
      OP_WORD_ADD_IMM = 6'b000011, OP_DIFF = 6'b000100, OP_DIFF_IMM = 6'b000101,
      OP_DIFF_BORROW = 6'b000110, OP_DIFF_BORROW_IMM = 6'b000111, OP_WORD_DIFF_IMM = 6'b001000,
      OP_CONJ = 6'b001001, OP_CONJ_IMM = 6'b001010, OP_DISJ = 6'b001011,
      OP_DISJ_IMM = 6'b001100, OP_XDISJ = 6'b001101, OP_BIT_INVERT = 6'b001110,
      OP_SIGN_FLIP = 6'b001111, OP_SET_BITS = 6'b010000, OP_CLEAR_BITS = 6'b010001,
      OP_PLUS_ONE = 6'b010010, OP_MINUS_ONE = 6'b010011, OP_ZERO_SIGN_PROBE = 6'b010100,
      OP_ZERO_REG = 6'b010101, OP_FILL_ONES = 6'b010110, OP_PROD_U = 6'b010111,
      OP_PROD_S = 6'b011000, OP_PROD_SU = 6'b011001, OP_FRAC_U = 6'b011010,
      OP_FRAC_S = 6'b011011, OP_FRAC_SU = 6'b011100, OP_REL_GOTO = 6'b011101,
      OP_PTR_GOTO = 6'b011110, OP_ABS_GOTO = 6'b011111, OP_REL_SUB = 6'b100000,
      OP_PTR_SUB = 6'b100001, OP_ABS_SUB = 6'b100010, OP_SUB_BACK = 6'b100011,
      OP_HANDLER_BACK = 6'b100100, OP_SKIP_EQUAL = 6'b100101, OP_COMPARE = 6'b100110,
      OP_COMPARE_BORROW = 6'b100111, OP_COMPARE_IMM = 6'b101000, OP_SKIP_REG_LOW = 6'b101001,
      OP_SKIP_REG_HIGH = 6'b101010, OP_SKIP_IO_LOW = 6'b101011, OP_SKIP_IO_HIGH = 6'b101100,
      OP_BR_FLAG_SET = 6'b101101, OP_BR_FLAG_CLEAR = 6'b101110, OP_BR_EQUAL = 6'b101111,
      OP_BR_NOT_EQUAL = 6'b110000, OP_BR_CARRY_SET = 6'b110001, OP_BR_CARRY_CLEAR = 6'b110010,
      OP_BR_SAME_HIGHER = 6'b110011, OP_BR_LOWER = 6'b110100, OP_BR_MINUS = 6'b110101,
      OP_BR_PLUS = 6'b110110, OP_BR_SIGNED_GE = 6'b110111, OP_BR_SIGNED_LT = 6'b111000,
      OP_BR_HALF_SET = 6'b111001, OP_BR_HALF_CLEAR = 6'b111010, OP_BR_TFLAG_SET = 6'b111011,
      OP_BR_TFLAG_CLEAR = 6'b111100, OP_BR_OVERFLOW_SET = 6'b111101
   } cab_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } cab_state_t;

   typedef struct packed {
      logic valid;
      cab_op_t op;
      logic [4:0] dst;
      logic [4:0] src;
      logic [7:0] imm;
      logic [2:0] bitSel;
      logic [11:0] offset;
      logic [15:0] target;
   } cab_cmd_t;

   typedef struct packed {
      cab_state_t state;
      logic [REG_COUNT-1:0][7:0] gpr;
      logic [7:0] status;
      logic [15:0] pc;
      logic [1:0] waitLeft;
      logic [7:0] rdData;
      logic done;
      logic push;
      logic [15:0] pushAddr;
   } cab_regs_t;

endpackage

// ---- logic/cab_exec.sv ----
`timescale 1ns/1ps
// How it works
// - Register add and add-with-carry write the sum, set Z C N V H, one cycle.
// - Word add/subtract immediate on a register pair, set Z C N V S, two cycles.
// - Subtract register or constant, borrow forms subtract carry, Z C N V H, one cycle.
// - AND and OR with register or constant, XOR with register, set only Z N V, one cycle.
// - Set-bits ORs a constant, clear-bits ANDs its complement, Z N V, one cycle.
// - Probe ANDs register with itself, zero XORs it, fill-ones sets 0xff without flags.
// - Integer products of two registers go to pair one:zero, set Z C, two cycles.
// - Fractional products are shifted left by one before writing, Z C, two cycles.
// - Relative goto and subroutine: PC gets PC plus offset plus one, two or three cycles.
// - Pointer goto and subroutine load PC from the Z pair, two or three cycles.
// - Absolute goto and subroutine load PC with the address, three or four cycles.
// - Skip-if-equal skips the next instruction when registers match, one to three cycles.
// - Compares subtract without storing, borrow form subtracts carry, set Z N V C H.
// - Register-bit skips skip when the chosen bit is clear or set, flags untouched.
// - I/O-bit skips test a bit of an I/O byte and skip likewise, flags untouched.
// - Flag branches test the indexed status bit, taken in two cycles, else one.
// - Equality branches test Z; carry, lower and same-or-higher branches test C.
// - Minus and plus test N; signed compares test N xor V.
// - Half-carry, T-flag and overflow branches use the same relative target.
module cab_exec
   import cab_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire cab_cmd_t cmd,
   output logic cmdReady,
   input wire logic nextTwoWord,
   input wire logic [7:0] ioByte,
   input wire logic [15:0] stackTop,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output logic [15:0] pc,
   output logic [7:0] status,
   output logic done,
   output logic pushReq,
   output logic [15:0] pushAddr
);

   // ----------------------------------------------------------------------
   // Flag helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] addFlags(input logic [7:0] s, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] r);
      logic [7:0] f;
      f = s;
      f[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      f[FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      f[FLAG_C] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      f[FLAG_N] = r[7];
      f[FLAG_Z] = (r == 8'h00);
      return f;
   endfunction

   // A chained subtract keeps Z only if every byte so far came out zero.
   function automatic logic [7:0] subFlags(input logic [7:0] s, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] r,
                                           input logic chain);
      logic [7:0] f;
      f = s;
      f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      f[FLAG_N] = r[7];
      f[FLAG_Z] = (r == 8'h00) & (~chain | s[FLAG_Z]);
      return f;
   endfunction

   function automatic logic [7:0] logicFlags(input logic [7:0] s, input logic [7:0] r);
      logic [7:0] f;
      f = s;
      f[FLAG_V] = 1'b0;
      f[FLAG_N] = r[7];
      f[FLAG_Z] = (r == 8'h00);
      return f;
   endfunction

   function automatic logic [7:0] busRead(input cab_regs_t s, input logic [7:0] addr);
      logic [7:0] d;
      d = 8'h00;
      if (addr <= ADDR_GPR_LAST)
         d = s.gpr[addr[4:0]];
      else if (addr == ADDR_STATUS)
         d = s.status;
      else if (addr == ADDR_PC_LO)
         d = s.pc[7:0];
      else if (addr == ADDR_PC_HI)
         d = s.pc[15:8];
      return d;
   endfunction

   // ----------------------------------------------------------------------
   // State and working values
   // ----------------------------------------------------------------------
   cab_regs_t q;
   cab_regs_t next_q;
   logic [7:0] opA;
   logic [7:0] opR;
   logic [7:0] opB;
   logic [7:0] res;
   logic cin;
   logic [15:0] word;
   logic [15:0] wordRes;
   logic [17:0] prodA;
   logic [17:0] prodB;
   logic [17:0] prodFull;
   logic [15:0] prod;
   logic [15:0] relTarget;
   logic [15:0] seqPc;
   logic [15:0] skipPc;
   logic [1:0] skipWait;
   logic cond;
   logic [4:0] dstHi;

   assign cmdReady = (q.state == ST_IDLE);
   assign regRdData = q.rdData;
   assign pc = q.pc;
   assign status = q.status;
   assign done = q.done;
   assign pushReq = q.push;
   assign pushAddr = q.pushAddr;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      next_q.done = 1'b0;
      next_q.push = 1'b0;
      opA = q.gpr[cmd.dst];
      opR = q.gpr[cmd.src];
      cin = q.status[FLAG_C];
      dstHi = 5'(cmd.dst + 5'h01);
      word = {q.gpr[dstHi], q.gpr[cmd.dst]};
      wordRes = 16'h0000;
      res = 8'h00;
      cond = 1'b0;
      seqPc = 16'(q.pc + 16'h0001);
      relTarget = 16'(q.pc + {{4{cmd.offset[11]}}, cmd.offset} + 16'h0001);
      skipPc = nextTwoWord ? 16'(q.pc + 16'h0003) : 16'(q.pc + 16'h0002);
      skipWait = nextTwoWord ? WAIT_3 : WAIT_2;
      case (cmd.op)
         OP_DIFF_IMM, OP_DIFF_BORROW_IMM, OP_CONJ_IMM, OP_DISJ_IMM, OP_SET_BITS, OP_COMPARE_IMM:
            opB = cmd.imm;
         OP_CLEAR_BITS:
            opB = ~cmd.imm;
         OP_ZERO_SIGN_PROBE, OP_ZERO_REG:
            opB = opA;
         default:
            opB = opR;
      endcase
      prodA = {{10{opA[7] & (cmd.op == OP_PROD_S || cmd.op == OP_PROD_SU ||
                              cmd.op == OP_FRAC_S || cmd.op == OP_FRAC_SU)}}, opA};
      prodB = {{10{opR[7] & (cmd.op == OP_PROD_S || cmd.op == OP_FRAC_S)}}, opR};
      prodFull = 18'(prodA * prodB);
      prod = prodFull[15:0];

      // Software access comes first so that an instruction taken in the same
      // cycle overrides it; the register port never stalls.
      if (regRd)
         next_q.rdData = busRead(q, regAddr);
      if (regWr)
      begin
         if (regAddr <= ADDR_GPR_LAST)
            next_q.gpr[regAddr[4:0]] = regWrData;
         else if (regAddr == ADDR_STATUS)
            next_q.status = regWrData;
         else if (regAddr == ADDR_PC_LO)
            next_q.pc[7:0] = regWrData;
         else if (regAddr == ADDR_PC_HI)
            next_q.pc[15:8] = regWrData;
      end

      case (q.state)
         ST_IDLE:
         begin
            if (cmd.valid)
            begin
               next_q.pc = seqPc;
               next_q.waitLeft = WAIT_1;
               case (cmd.op)
                  OP_SUM, OP_SUM_CARRY:
                  begin
                     res = 8'(opA + opB + {7'h00, cin & (cmd.op == OP_SUM_CARRY)});
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = addFlags(q.status, opA, opB, res);
                  end
                  OP_WORD_ADD_IMM, OP_WORD_DIFF_IMM:
                  begin
                     if (cmd.op == OP_WORD_ADD_IMM)
                     begin
                        wordRes = 16'(word + {10'h000, cmd.imm[5:0]});
                        next_q.status[FLAG_V] = ~word[15] & wordRes[15];
                        next_q.status[FLAG_C] = ~wordRes[15] & word[15];
                     end
                     else
                     begin
                        wordRes = 16'(word - {10'h000, cmd.imm[5:0]});
                        next_q.status[FLAG_V] = word[15] & ~wordRes[15];
                        next_q.status[FLAG_C] = wordRes[15] & ~word[15];
                     end
                     next_q.gpr[cmd.dst] = wordRes[7:0];
                     next_q.gpr[dstHi] = wordRes[15:8];
                     next_q.status[FLAG_N] = wordRes[15];
                     next_q.status[FLAG_Z] = (wordRes == 16'h0000);
                     next_q.status[FLAG_S] = wordRes[15] ^ next_q.status[FLAG_V];
                     next_q.waitLeft = WAIT_2;
                  end
                  OP_DIFF, OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_BORROW_IMM,
                  OP_COMPARE, OP_COMPARE_BORROW, OP_COMPARE_IMM:
                  begin
                     cond = (cmd.op == OP_DIFF_BORROW || cmd.op == OP_DIFF_BORROW_IMM ||
                             cmd.op == OP_COMPARE_BORROW);
                     res = 8'(opA - opB - {7'h00, cin & cond});
                     next_q.status = subFlags(q.status, opA, opB, res, cond);
                     if (cmd.op != OP_COMPARE && cmd.op != OP_COMPARE_BORROW && cmd.op != OP_COMPARE_IMM)
                        next_q.gpr[cmd.dst] = res;
                  end
                  OP_CONJ, OP_CONJ_IMM, OP_CLEAR_BITS, OP_ZERO_SIGN_PROBE:
                  begin
                     res = opA & opB;
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = logicFlags(q.status, res);
                  end
                  OP_DISJ, OP_DISJ_IMM, OP_SET_BITS:
                  begin
                     res = opA | opB;
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = logicFlags(q.status, res);
                  end
                  OP_XDISJ, OP_ZERO_REG:
                  begin
                     res = opA ^ opB;
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = logicFlags(q.status, res);
                  end
                  OP_FILL_ONES:
                     next_q.gpr[cmd.dst] = 8'hff;
                  OP_BIT_INVERT:
                  begin
                     res = 8'hff - opA;
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = logicFlags(q.status, res);
                     next_q.status[FLAG_C] = 1'b1;
                  end
                  OP_SIGN_FLIP:
                  begin
                     res = 8'(8'h00 - opA);
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = subFlags(q.status, 8'h00, opA, res, 1'b0);
                  end
                  OP_PLUS_ONE, OP_MINUS_ONE:
                  begin
                     res = (cmd.op == OP_PLUS_ONE) ? 8'(opA + 8'h01) : 8'(opA - 8'h01);
                     next_q.gpr[cmd.dst] = res;
                     next_q.status = logicFlags(q.status, res);
                     next_q.status[FLAG_V] = (cmd.op == OP_PLUS_ONE) ? (res == 8'h80) : (res == 8'h7f);
                  end
                  OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU:
                  begin
                     // Carry is the product's top bit before the fractional shift.
                     next_q.status[FLAG_C] = prod[15];
                     if (cmd.op == OP_FRAC_U || cmd.op == OP_FRAC_S || cmd.op == OP_FRAC_SU)
                        wordRes = {prod[14:0], 1'b0};
                     else
                        wordRes = prod;
                     next_q.gpr[PAIR_PRODUCT_LO] = wordRes[7:0];
                     next_q.gpr[PAIR_PRODUCT_HI] = wordRes[15:8];
                     next_q.status[FLAG_Z] = (wordRes == 16'h0000);
                     next_q.waitLeft = WAIT_2;
                  end
                  OP_REL_GOTO, OP_REL_SUB:
                  begin
                     next_q.pc = relTarget;
                     next_q.waitLeft = (cmd.op == OP_REL_SUB) ? WAIT_3 : WAIT_2;
                     next_q.push = (cmd.op == OP_REL_SUB);
                     next_q.pushAddr = seqPc;
                  end
                  OP_PTR_GOTO, OP_PTR_SUB:
                  begin
                     next_q.pc = {q.gpr[PAIR_POINTER_HI], q.gpr[PAIR_POINTER_LO]};
                     next_q.waitLeft = (cmd.op == OP_PTR_SUB) ? WAIT_3 : WAIT_2;
                     next_q.push = (cmd.op == OP_PTR_SUB);
                     next_q.pushAddr = seqPc;
                  end
                  OP_ABS_GOTO, OP_ABS_SUB:
                  begin
                     next_q.pc = cmd.target;
                     next_q.waitLeft = (cmd.op == OP_ABS_SUB) ? WAIT_4 : WAIT_3;
                     // The absolute forms occupy two words, so the return skips both.
                     next_q.push = (cmd.op == OP_ABS_SUB);
                     next_q.pushAddr = 16'(q.pc + 16'h0002);
                  end
                  OP_SUB_BACK, OP_HANDLER_BACK:
                  begin
                     next_q.pc = stackTop;
                     next_q.waitLeft = WAIT_4;
                     if (cmd.op == OP_HANDLER_BACK)
                        next_q.status[FLAG_I] = 1'b1;
                  end
                  OP_SKIP_EQUAL, OP_SKIP_REG_LOW, OP_SKIP_REG_HIGH, OP_SKIP_IO_LOW, OP_SKIP_IO_HIGH:
                  begin
                     case (cmd.op)
                        OP_SKIP_EQUAL: cond = (opA == opR);
                        OP_SKIP_REG_LOW: cond = ~opR[cmd.bitSel];
                        OP_SKIP_REG_HIGH: cond = opR[cmd.bitSel];
                        OP_SKIP_IO_LOW: cond = ~ioByte[cmd.bitSel];
                        default: cond = ioByte[cmd.bitSel];
                     endcase
                     if (cond)
                     begin
                        next_q.pc = skipPc;
                        next_q.waitLeft = skipWait;
                     end
                  end
                  OP_IDLE:
                     next_q.pc = seqPc;
                  default:
                  begin
                     case (cmd.op)
                        OP_BR_FLAG_SET: cond = q.status[cmd.bitSel];
                        OP_BR_FLAG_CLEAR: cond = ~q.status[cmd.bitSel];
                        OP_BR_EQUAL: cond = q.status[FLAG_Z];
                        OP_BR_NOT_EQUAL: cond = ~q.status[FLAG_Z];
                        OP_BR_CARRY_SET, OP_BR_LOWER: cond = q.status[FLAG_C];
                        OP_BR_CARRY_CLEAR, OP_BR_SAME_HIGHER: cond = ~q.status[FLAG_C];
                        OP_BR_MINUS: cond = q.status[FLAG_N];
                        OP_BR_PLUS: cond = ~q.status[FLAG_N];
                        OP_BR_SIGNED_GE: cond = ~(q.status[FLAG_N] ^ q.status[FLAG_V]);
                        OP_BR_SIGNED_LT: cond = q.status[FLAG_N] ^ q.status[FLAG_V];
                        OP_BR_HALF_SET: cond = q.status[FLAG_H];
                        OP_BR_HALF_CLEAR: cond = ~q.status[FLAG_H];
                        OP_BR_TFLAG_SET: cond = q.status[FLAG_T];
                        OP_BR_TFLAG_CLEAR: cond = ~q.status[FLAG_T];
                        OP_BR_OVERFLOW_SET: cond = q.status[FLAG_V];
                        default: cond = 1'b0;
                     endcase
                     if (cond)
                     begin
                        next_q.pc = relTarget;
                        next_q.waitLeft = WAIT_2;
                     end
                  end
               endcase
               if (next_q.waitLeft == WAIT_1)
                  next_q.done = 1'b1;
               else
                  next_q.state = ST_BUSY;
            end
         end
         ST_BUSY:
         begin
            next_q.waitLeft = 2'(q.waitLeft - 2'h1);
            if (q.waitLeft == WAIT_2)
            begin
               next_q.state = ST_IDLE;
               next_q.done = 1'b1;
            end
         end
         default:
            next_q.state = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         q <= '0;
         q.state <= ST_IDLE;
         q.status <= STATUS_RESET;
         q.pc <= PC_RESET;
         q.waitLeft <= WAIT_1;
      end
      else
         q <= next_q;
   end

endmodule

// ---- sim/cab_prog_mem.sv ----
`timescale 1ns/1ps
module cab_prog_mem
   import cab_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmdReady,
   input wire logic load,
   input wire cab_cmd_t word,
   output cab_cmd_t cmd
);
   // A fetched word is held until taken; after that the bus shows junk, so a stale word cannot pass.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cmd <= '0;
      else if (load)
         cmd <= word;
      else if (cmd.valid && cmdReady)
         cmd <= {1'b0, ~cmd[$bits(cab_cmd_t)-2:0]};
   end
endmodule

// ---- sim/cab_exec_props.sv ----
`timescale 1ns/1ps
module cab_exec_props
   import cab_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire cab_cmd_t cmd,
   input wire logic cmdReady,
   input wire logic [15:0] pc,
   input wire logic [7:0] status,
   input wire logic done,
   input wire logic pushReq,
   input wire logic [15:0] pushAddr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic tk;
   logic [15:0] rel;
   assign tk = cmd.valid && cmdReady;
   assign rel = pc + {{4{cmd.offset[11]}}, cmd.offset} + 16'h1;
   a_sum_one_cycle: assert property (
      tk && cmd.op == OP_SUM |=> done) else $error("sum late");
   a_product_two_cycles: assert property (
      tk && cmd.op == OP_PROD_U |=> !done && !cmdReady ##1 done) else $error("product timing");
   a_logic_keeps_flags: assert property (
      tk && cmd.op == OP_CONJ_IMM |=> (status & 8'hf1) == ($past(status) & 8'hf1)) else $error("logic flags");
   a_branch_taken_target: assert property (
      tk && cmd.op == OP_BR_LOWER && status[FLAG_C] |=> pc == $past(rel) && !done ##1 done) else $error("taken");
   a_branch_fall_through: assert property (
      tk && cmd.op == OP_BR_SAME_HIGHER && status[FLAG_C] |=> pc == $past(pc) + 16'h1 && done) else $error("fall");
   a_call_push_addr: assert property (
      tk && cmd.op == OP_ABS_SUB |=> pushReq && pushAddr == $past(pc) + 16'h2 && pc == $past(cmd.target))
      else $error("call push");
   a_call_four_cycles: assert property (
      tk && cmd.op == OP_ABS_SUB |=> !cmdReady [*3] ##1 done) else $error("call timing");
   a_return_four_cycles: assert property (
      tk && cmd.op == OP_SUB_BACK |=> !done [*3] ##1 done) else $error("return timing");
   a_skip_keeps_flags: assert property (
      tk && cmd.op == OP_SKIP_IO_HIGH |=> status == $past(status)) else $error("skip flags");
endmodule
bind cab_exec cab_exec_props u_props (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .cmdReady(cmdReady), .pc(pc),
   .status(status), .done(done), .pushReq(pushReq), .pushAddr(pushAddr));

// ---- sim/cab_exec_tb_top.sv ----
`timescale 1ns/1ps
module cab_exec_tb_top
   import cab_pkg::*;
;
   logic clk_sys, rst, cmdReady, load, nextTwoWord, regWr, regRd, done, pushReq;
   logic [7:0] ioByte, regAddr, regWrData, regRdData, status;
   logic [15:0] stackTop, pc, pushAddr;
   cab_cmd_t word, cmd;
   int err_total, n_checks;
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   cab_prog_mem u_mem (.clk_sys(clk_sys), .rst(rst), .cmdReady(cmdReady), .load(load), .word(word), .cmd(cmd));
   cab_exec DUT (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .cmdReady(cmdReady), .nextTwoWord(nextTwoWord),
      .ioByte(ioByte), .stackTop(stackTop), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .pc(pc), .status(status), .done(done), .pushReq(pushReq), .pushAddr(pushAddr));
   task automatic end_sim();
      if (err_total == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      chk(regRdData, e);
   endtask
   task automatic run(input cab_op_t op, input logic [4:0] d, input logic [4:0] s, input logic [11:0] o);
      int w;
      @(posedge clk_sys);
      // The immediate reuses the offset's low byte, so one argument serves both kinds.
      word <= '{1'b1, op, d, s, o[7:0], s[2:0], o, 16'h0040};
      load <= 1'b1;
      @(posedge clk_sys);
      load <= 1'b0;
      for (w = 0; w < 8; w++)
      begin
         @(negedge clk_sys);
         if (done === 1'b1)
            break;
      end
      if (w == 8)
      begin
         err_total++;
         end_sim();
      end
   endtask
   initial
   begin
      rst = 1'b1;
      load = 1'b0;
      word = '0;
      nextTwoWord = 1'b1;
      ioByte = 8'h08;
      stackTop = 16'h0123;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      wr(8'h10, 8'h7f);
      wr(8'h11, 8'h01);
      run(OP_SUM, 5'h10, 5'h11, 12'h000);
      rd(8'h10, 8'h80);
      rd(8'h20, 8'h2c);
      run(OP_CONJ_IMM, 5'h10, 5'h11, 12'h0c0);
      rd(8'h10, 8'h80);
      rd(8'h20, 8'h24);
      wr(8'h12, 8'hff);
      wr(8'h13, 8'hff);
      run(OP_PROD_U, 5'h12, 5'h13, 12'h000);
      rd(8'h00, 8'h01);
      rd(8'h01, 8'hfe);
      run(OP_FRAC_U, 5'h12, 5'h13, 12'h000);
      rd(8'h00, 8'h02);
      rd(8'h20, 8'h25);
      run(OP_BR_LOWER, 5'h00, 5'h00, 12'hffe);
      run(OP_BR_SAME_HIGHER, 5'h00, 5'h00, 12'h005);
      rd(8'h21, 8'h04);
      run(OP_ABS_SUB, 5'h00, 5'h00, 12'h000);
      chk(pushAddr, 16'h0006);
      rd(8'h21, 8'h40);
      run(OP_SUB_BACK, 5'h00, 5'h00, 12'h000);
      rd(8'h22, 8'h01);
      run(OP_SKIP_IO_HIGH, 5'h00, 5'h03, 12'h000);
      rd(8'h21, 8'h26);
      @(posedge clk_sys);
      nextTwoWord <= 1'b0;
      run(OP_SKIP_IO_HIGH, 5'h00, 5'h02, 12'h000);
      run(OP_SKIP_IO_LOW, 5'h00, 5'h02, 12'h000);
      rd(8'h21, 8'h29);
      run(OP_DIFF, 5'h10, 5'h11, 12'h000);
      rd(8'h10, 8'h7f);
      rd(8'h20, 8'h28);
      run(OP_BR_SIGNED_LT, 5'h00, 5'h00, 12'h010);
      run(OP_COMPARE_IMM, 5'h10, 5'h00, 12'h07f);
      rd(8'h20, 8'h02);
      run(OP_BR_EQUAL, 5'h00, 5'h00, 12'hff0);
      rd(8'h21, 8'h2d);
      run(OP_PLUS_ONE, 5'h10, 5'h00, 12'h000);
      rd(8'h20, 8'h0c);
      run(OP_SIGN_FLIP, 5'h10, 5'h00, 12'h000);
      rd(8'h20, 8'h0d);
      run(OP_BIT_INVERT, 5'h11, 5'h00, 12'h000);
      rd(8'h20, 8'h05);
      run(OP_WORD_ADD_IMM, 5'h12, 5'h00, 12'h002);
      rd(8'h13, 8'h00);
      rd(8'h20, 8'h01);
      wr(8'h1e, 8'h55);
      run(OP_PTR_GOTO, 5'h00, 5'h00, 12'h000);
      rd(8'h21, 8'h55);
      run(OP_REL_SUB, 5'h00, 5'h00, 12'h00a);
      chk(pushAddr, 16'h0056);
      rd(8'h21, 8'h60);
      run(OP_SKIP_EQUAL, 5'h12, 5'h12, 12'h000);
      run(OP_SKIP_REG_HIGH, 5'h00, 5'h11, 12'h000);
      rd(8'h21, 8'h64);
      run(OP_BR_FLAG_SET, 5'h00, 5'h00, 12'h004);
      run(OP_FILL_ONES, 5'h14, 5'h00, 12'h000);
      run(OP_CLEAR_BITS, 5'h14, 5'h00, 12'h0f0);
      rd(8'h14, 8'h0f);
      rd(8'h21, 8'h6b);
      rd(8'h30, 8'h00);
      end_sim();
   end
endmodule
